// ==== core/twm_pkg.sv ====
// Shared constants and types for the two-wire master status engine.
//
// Notes on behaviour
// - Enable plus start request begins; START when free.
// - After START: event flag, status 08h.
// - Status 08h: send address byte, sample acknowledge.
// - Status 10h: read address enters receive mode.
// - Receive mode, write address returns to transmit.
// - Transmit codes 18h, 20h, 28h, 30h, 38h.
// - Transmit statuses except 38h: send loaded data byte.
// - Start only response issues repeated START.
// - Stop only issues STOP; stop bit self-clears.
// - Start and stop: STOP then START, self-clear.
// - 38h without start: release bus, not addressed.
// - 38h with start: START once bus free.
// - Read address result: 40h, 48h or 38h.
// - 40h/50h: receive byte, acknowledge per enable.
// - 50h byte acknowledged; 58h byte not acknowledged.
// - 48h: only restart, stop or stop-start.
// - Received byte readable while event flag set.
// - Nothing continues until event flag cleared.
// - Serial clock held low while flag set, except at 38h.
// - No event flag after a STOP.
// - Direction bit low write, high read.
package twm_pkg;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TWM_ST_START = 8'h08;
  localparam logic [7:0] TWM_ST_RSTART = 8'h10;
  localparam logic [7:0] TWM_ST_AW_ACK = 8'h18;
  localparam logic [7:0] TWM_ST_AW_NACK = 8'h20;
  localparam logic [7:0] TWM_ST_DT_ACK = 8'h28;
  localparam logic [7:0] TWM_ST_DT_NACK = 8'h30;
  localparam logic [7:0] TWM_ST_ARB = 8'h38;
  localparam logic [7:0] TWM_ST_AR_ACK = 8'h40;
  localparam logic [7:0] TWM_ST_AR_NACK = 8'h48;
  localparam logic [7:0] TWM_ST_RX_ACK = 8'h50;
  localparam logic [7:0] TWM_ST_RX_NACK = 8'h58;
  localparam logic [7:0] TWM_ST_IDLE = 8'hf8;

  // ----------------------------------------------------------------
  // Fields, reset values and counts
  // ----------------------------------------------------------------
  localparam int TWM_DIR_POS = 0;
  localparam logic TWM_DIR_READ = 1'b1;
  localparam logic [7:0] TWM_DATA_RESET = 8'h00;
  localparam logic [3:0] TWM_ACK_BIT_IDX = 4'h8;
  localparam int TWM_QUARTER_CYCLES = 4;

  // ----------------------------------------------------------------
  // Commands passed to the bit engine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TWM_CMD_NONE,
    TWM_CMD_START,
    TWM_CMD_RSTART,
    TWM_CMD_STOP,
    TWM_CMD_STOP_START,
    TWM_CMD_TX,
    TWM_CMD_RX
  } twm_cmd_t;

endpackage : twm_pkg

// ==== core/twm_link_if.sv ====
// Command and result link between the status engine and the bit engine.
`timescale 1ns/100ps
interface twm_link_if;
  logic reqToggle;
  twm_pkg::twm_cmd_t cmd;
  logic [7:0] txByte;
  logic ackOut;
  logic doneToggle;
  logic ackSeen;
  logic arbLost;
  logic [7:0] rxByte;

  modport ctl (
    output reqToggle, cmd, txByte, ackOut,
    input doneToggle, ackSeen, arbLost, rxByte
  );
  modport eng (
    input reqToggle, cmd, txByte, ackOut,
    output doneToggle, ackSeen, arbLost, rxByte
  );
endinterface : twm_link_if

// ==== core/twm_bit_engine.sv ====
// Bit-level serial engine running on the link clock.
`timescale 1ns/100ps
module twm_bit_engine #(
  parameter int QUARTER_CYCLES = twm_pkg::TWM_QUARTER_CYCLES
) (
  input wire logic busClk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  twm_link_if.eng link,
  output logic sclOut,
  output logic sclOeN,
  output logic sdaOut,
  output logic sdaOeN
);
  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} twm_eng_state_t;

  logic sclMeta, sclSync, sdaMeta, sdaSync, reqMeta, reqSync, enMeta, enSync;
  logic sclLast, sdaLast, busBusy, reqSeen, tick, txBit, waitFree;
  logic [15:0] qCount;
  twm_eng_state_t state;
  logic [1:0] phase;
  logic [3:0] bitIdx;
  logic [7:0] shiftReg;
  twm_pkg::twm_cmd_t cmdHeld;
  logic ackDrive;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge busClk or posedge reset) begin
    if (reset) begin
      {sclMeta, sclSync, sdaMeta, sdaSync} <= 4'hf;
      {reqMeta, reqSync, enMeta, enSync} <= 4'h0;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      reqMeta <= link.reqToggle;
      reqSync <= reqMeta;
      enMeta <= clkEn;
      enSync <= enMeta;
    end
  end

  // ----------------------------------------------------------------
  // Bus free detection and quarter-bit timer
  // ----------------------------------------------------------------
  always_ff @(posedge busClk or posedge reset) begin
    if (reset) begin
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
      busBusy <= 1'b0;
      qCount <= 16'h0000;
    end else if (enSync) begin
      sclLast <= sclSync;
      sdaLast <= sdaSync;
      if (sclSync && sclLast && sdaLast && !sdaSync) begin
        busBusy <= 1'b1;
      end else if (sclSync && sclLast && !sdaLast && sdaSync) begin
        busBusy <= 1'b0;
      end
      qCount <= tick ? 16'h0000 : qCount + 16'h0001;
    end
  end

  assign tick = (qCount == 16'(QUARTER_CYCLES - 1));
  assign waitFree = busBusy && (cmdHeld != twm_pkg::TWM_CMD_RSTART);
  always_comb begin
    if (cmdHeld == twm_pkg::TWM_CMD_TX) begin
      txBit = (bitIdx < twm_pkg::TWM_ACK_BIT_IDX) ? shiftReg[7] : 1'b1;
    end else begin
      txBit = (bitIdx < twm_pkg::TWM_ACK_BIT_IDX) ? 1'b1 : ~ackDrive;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge busClk or posedge reset) begin
    if (reset) begin
      state <= E_IDLE;
      phase <= 2'h0;
      bitIdx <= 4'h0;
      shiftReg <= twm_pkg::TWM_DATA_RESET;
      cmdHeld <= twm_pkg::TWM_CMD_NONE;
      ackDrive <= 1'b0;
      reqSeen <= 1'b0;
      link.doneToggle <= 1'b0;
      link.ackSeen <= 1'b0;
      link.arbLost <= 1'b0;
      link.rxByte <= twm_pkg::TWM_DATA_RESET;
      sclOeN <= 1'b1;
      sdaOeN <= 1'b1;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else if (enSync) begin
      case (state)
        E_IDLE: begin
          if (reqSync != reqSeen) begin
            reqSeen <= reqSync;
            cmdHeld <= link.cmd;
            shiftReg <= link.txByte;
            ackDrive <= link.ackOut;
            link.arbLost <= 1'b0;
            bitIdx <= 4'h0;
            phase <= 2'h0;
            if (link.cmd == twm_pkg::TWM_CMD_TX || link.cmd == twm_pkg::TWM_CMD_RX) begin
              state <= E_BIT;
            end else if (link.cmd == twm_pkg::TWM_CMD_STOP ||
                         link.cmd == twm_pkg::TWM_CMD_STOP_START) begin
              state <= E_STOP;
            end else begin
              state <= E_START;
            end
          end
        end
        E_START: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sdaOeN <= 1'b1;
            2'h1: sclOeN <= 1'b1;
            2'h2: begin
              if (waitFree) begin
                phase <= phase;
              end else begin
                sdaOeN <= 1'b0;
              end
            end
            default: begin
              sclOeN <= 1'b0;
              state <= E_IDLE;
              link.doneToggle <= ~link.doneToggle;
            end
          endcase
        end
        E_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              sclOeN <= 1'b0;
              sdaOeN <= 1'b0;
            end
            2'h1: sclOeN <= 1'b1;
            2'h2: sdaOeN <= 1'b1;
            default: begin
              if (cmdHeld == twm_pkg::TWM_CMD_STOP_START) begin
                state <= E_START;
              end else begin
                state <= E_IDLE;
                link.doneToggle <= ~link.doneToggle;
              end
            end
          endcase
        end
        E_BIT: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sdaOeN <= txBit;
            2'h1: sclOeN <= 1'b1;
            2'h2: begin
              if (bitIdx < twm_pkg::TWM_ACK_BIT_IDX) begin
                shiftReg <= {shiftReg[6:0], sdaSync};
              end
              if (cmdHeld == twm_pkg::TWM_CMD_TX && sdaOeN && !sdaSync &&
                  bitIdx < twm_pkg::TWM_ACK_BIT_IDX) begin
                sclOeN <= 1'b1;
                link.arbLost <= 1'b1;
                state <= E_IDLE;
                link.doneToggle <= ~link.doneToggle;
              end
              if (bitIdx == twm_pkg::TWM_ACK_BIT_IDX) begin
                link.ackSeen <= (cmdHeld == twm_pkg::TWM_CMD_TX) ? !sdaSync : ackDrive;
              end
            end
            default: begin
              sclOeN <= 1'b0;
              if (bitIdx == twm_pkg::TWM_ACK_BIT_IDX) begin
                link.rxByte <= shiftReg;
                state <= E_IDLE;
                link.doneToggle <= ~link.doneToggle;
              end else begin
                bitIdx <= bitIdx + 4'h1;
              end
            end
          endcase
        end
        default: state <= E_IDLE;
      endcase
    end
  end

endmodule : twm_bit_engine

// ==== core/two_wire_master_status_engine.sv ====
// Master-side status engine for a two-wire serial interface.
`timescale 1ns/100ps
module two_wire_master_status_engine #(
  parameter int QUARTER_CYCLES = twm_pkg::TWM_QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic busClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOeN,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic ctrlWrite,
  input wire logic ctrlEnable,
  input wire logic ctrlStart,
  input wire logic ctrlStop,
  input wire logic ctrlAck,
  input wire logic ctrlClearEvent,
  input wire logic dataWrite,
  input wire logic [7:0] dataIn,
  output logic interfaceEnableBit,
  output logic startRequestBit,
  output logic stopRequestBit,
  output logic ackEnableBit,
  output logic serialEventFlag,
  output logic [7:0] busStatusCodeReg,
  output logic [7:0] busDataReg,
  output logic masterReceiveMode
);

  typedef enum logic [1:0] {M_IDLE, M_WAIT, M_BUSY} twm_ctl_state_t;

  // ----------------------------------------------------------------
  // Response decoding
  // ----------------------------------------------------------------
  function automatic logic twm_is_address_phase(input logic [7:0] code);
    return (code == twm_pkg::TWM_ST_START) || (code == twm_pkg::TWM_ST_RSTART);
  endfunction : twm_is_address_phase

  function automatic twm_pkg::twm_cmd_t twm_respond(
    input logic [7:0] code,
    input logic start_request_bit,
    input logic stop_request_bit
  );
    twm_pkg::twm_cmd_t result;
    result = twm_pkg::TWM_CMD_TX;
    if (code == twm_pkg::TWM_ST_ARB) begin
      result = start_request_bit ? twm_pkg::TWM_CMD_START : twm_pkg::TWM_CMD_NONE;
    end else if (twm_is_address_phase(code)) begin
      result = twm_pkg::TWM_CMD_TX;
    end else if (start_request_bit && stop_request_bit) begin
      result = twm_pkg::TWM_CMD_STOP_START;
    end else if (stop_request_bit) begin
      result = twm_pkg::TWM_CMD_STOP;
    end else if (start_request_bit) begin
      result = twm_pkg::TWM_CMD_RSTART;
    end else if (code == twm_pkg::TWM_ST_AR_ACK || code == twm_pkg::TWM_ST_RX_ACK) begin
      result = twm_pkg::TWM_CMD_RX;
    end else if (code == twm_pkg::TWM_ST_AR_NACK || code == twm_pkg::TWM_ST_RX_NACK) begin
      result = twm_pkg::TWM_CMD_STOP;
    end
    return result;
  endfunction : twm_respond

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  twm_link_if link ();

  twm_ctl_state_t state;
  twm_pkg::twm_cmd_t nextCmd;
  logic doneMeta, doneSync, doneSeen, doneEdge;
  logic addrPhase, finished;
  logic postFlag, hwStopClear, rxLoad, addrRead;
  logic [7:0] postCode;

  // ----------------------------------------------------------------
  // Bit engine on the link clock
  // ----------------------------------------------------------------
  twm_bit_engine #(
    .QUARTER_CYCLES(QUARTER_CYCLES)
  ) u_engine (
    .busClk(busClk),
    .reset(reset),
    .clkEn(clkEn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .link(link.eng),
    .sclOut(sclOut),
    .sclOeN(sclOeN),
    .sdaOut(sdaOut),
    .sdaOeN(sdaOeN)
  );

  // ----------------------------------------------------------------
  // Completion crossing from the link domain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      doneMeta <= 1'b0;
      doneSync <= 1'b0;
    end else begin
      doneMeta <= link.doneToggle;
      doneSync <= doneMeta;
    end
  end

  assign doneEdge = doneSync ^ doneSeen;
  assign finished = (state == M_BUSY) && doneEdge;
  assign addrRead = (link.txByte[twm_pkg::TWM_DIR_POS] == twm_pkg::TWM_DIR_READ);

  // ----------------------------------------------------------------
  // Status posted on completion
  // ----------------------------------------------------------------
  always_comb begin
    postFlag = 1'b0;
    postCode = busStatusCodeReg;
    hwStopClear = 1'b0;
    rxLoad = 1'b0;
    if (finished) begin
      case (link.cmd)
        twm_pkg::TWM_CMD_START: begin
          postFlag = 1'b1;
          postCode = twm_pkg::TWM_ST_START;
        end
        twm_pkg::TWM_CMD_STOP_START: begin
          postFlag = 1'b1;
          postCode = twm_pkg::TWM_ST_START;
          hwStopClear = 1'b1;
        end
        twm_pkg::TWM_CMD_RSTART: begin
          postFlag = 1'b1;
          postCode = twm_pkg::TWM_ST_RSTART;
        end
        twm_pkg::TWM_CMD_STOP: begin
          hwStopClear = 1'b1;
        end
        twm_pkg::TWM_CMD_TX: begin
          postFlag = 1'b1;
          if (link.arbLost) begin
            postCode = twm_pkg::TWM_ST_ARB;
          end else if (addrPhase && addrRead) begin
            postCode = link.ackSeen ? twm_pkg::TWM_ST_AR_ACK : twm_pkg::TWM_ST_AR_NACK;
          end else if (addrPhase) begin
            postCode = link.ackSeen ? twm_pkg::TWM_ST_AW_ACK : twm_pkg::TWM_ST_AW_NACK;
          end else begin
            postCode = link.ackSeen ? twm_pkg::TWM_ST_DT_ACK : twm_pkg::TWM_ST_DT_NACK;
          end
        end
        twm_pkg::TWM_CMD_RX: begin
          postFlag = 1'b1;
          rxLoad = 1'b1;
          postCode = link.ackSeen ? twm_pkg::TWM_ST_RX_ACK : twm_pkg::TWM_ST_RX_NACK;
        end
        default: postFlag = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interfaceEnableBit <= 1'b0;
      startRequestBit <= 1'b0;
      stopRequestBit <= 1'b0;
      ackEnableBit <= 1'b0;
    end else if (clkEn) begin
      if (ctrlWrite) begin
        interfaceEnableBit <= ctrlEnable;
        startRequestBit <= ctrlStart;
        ackEnableBit <= ctrlAck;
      end
      if (ctrlWrite && ctrlStop) begin
        stopRequestBit <= 1'b1;
      end else if (ctrlWrite || hwStopClear) begin
        stopRequestBit <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flag: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serialEventFlag <= 1'b0;
    end else if (clkEn) begin
      if (postFlag) begin
        serialEventFlag <= 1'b1;
      end else if (ctrlWrite && ctrlClearEvent) begin
        serialEventFlag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status code
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busStatusCodeReg <= twm_pkg::TWM_ST_IDLE;
    end else if (clkEn) begin
      if (postFlag) begin
        busStatusCodeReg <= postCode;
      end else if (finished && hwStopClear) begin
        busStatusCodeReg <= twm_pkg::TWM_ST_IDLE;
      end else if (state == M_WAIT && !serialEventFlag && nextCmd == twm_pkg::TWM_CMD_NONE) begin
        busStatusCodeReg <= twm_pkg::TWM_ST_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data register: writes only land while the flag is set
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busDataReg <= twm_pkg::TWM_DATA_RESET;
    end else if (clkEn) begin
      if (rxLoad) begin
        busDataReg <= link.rxByte;
      end else if (dataWrite && serialEventFlag) begin
        busDataReg <= dataIn;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencing and command issue
  // ----------------------------------------------------------------
  assign nextCmd = twm_respond(busStatusCodeReg, startRequestBit, stopRequestBit);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= M_IDLE;
      doneSeen <= 1'b0;
      addrPhase <= 1'b0;
      masterReceiveMode <= 1'b0;
      link.reqToggle <= 1'b0;
      link.cmd <= twm_pkg::TWM_CMD_NONE;
      link.txByte <= twm_pkg::TWM_DATA_RESET;
      link.ackOut <= 1'b0;
    end else if (clkEn) begin
      doneSeen <= doneSync;
      case (state)
        M_IDLE: begin
          if (interfaceEnableBit && startRequestBit && !serialEventFlag) begin
            link.cmd <= twm_pkg::TWM_CMD_START;
            link.reqToggle <= ~link.reqToggle;
            addrPhase <= 1'b0;
            state <= M_BUSY;
          end
        end
        M_WAIT: begin
          // Bus clock stays low in the engine until a response issues, except after 38h, where it is released
          if (!serialEventFlag) begin
            if (!interfaceEnableBit || nextCmd == twm_pkg::TWM_CMD_NONE) begin
              masterReceiveMode <= 1'b0;
              state <= M_IDLE;
            end else begin
              link.cmd <= nextCmd;
              link.txByte <= busDataReg;
              link.ackOut <= ackEnableBit;
              addrPhase <= twm_is_address_phase(busStatusCodeReg);
              link.reqToggle <= ~link.reqToggle;
              state <= M_BUSY;
            end
          end
        end
        M_BUSY: begin
          if (doneEdge) begin
            if (link.cmd == twm_pkg::TWM_CMD_TX && addrPhase && !link.arbLost) begin
              masterReceiveMode <= addrRead;
            end
            state <= (link.cmd == twm_pkg::TWM_CMD_STOP) ? M_IDLE : M_WAIT;
          end
        end
        default: state <= M_IDLE;
      endcase
    end
  end

endmodule : two_wire_master_status_engine

// ==== testbench/twm_chk.sv ====
// Port-level checks for the two-wire master status engine.
`timescale 1ns/100ps
module twm_chk #(
  parameter int QUARTER_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sclOeN,
  input wire logic sdaOeN,
  input wire logic ctrlWrite,
  input wire logic ctrlClearEvent,
  input wire logic dataWrite,
  input wire logic startRequestBit,
  input wire logic stopRequestBit,
  input wire logic serialEventFlag,
  input wire logic [7:0] busStatusCodeReg,
  input wire logic [7:0] busDataReg,
  input wire logic masterReceiveMode
);
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_flag_holds_clock: assert property (
    serialEventFlag && busStatusCodeReg != 8'h38 |-> !sclOeN) else $error("clock not held");
  a_stall_lines: assert property (
    serialEventFlag && $past(serialEventFlag) |-> $stable(sclOeN) && $stable(sdaOeN))
    else $error("bus moved while flag set");
  a_stop_no_flag: assert property (
    $fell(stopRequestBit) && !$past(ctrlWrite) && !startRequestBit |-> !serialEventFlag [*8])
    else $error("flag after stop");
  a_stop_self_clear: assert property (
    $rose(stopRequestBit) && !serialEventFlag |-> ##[1:600] !stopRequestBit)
    else $error("stop bit stuck");
  a_clear_event: assert property (
    ctrlWrite && clkEn && ctrlClearEvent && serialEventFlag |=> !serialEventFlag)
    else $error("flag not cleared");
  a_data_refused: assert property (
    dataWrite && clkEn && !serialEventFlag && !masterReceiveMode |=> $stable(busDataReg))
    else $error("data write taken");
  a_legal_code: assert property (
    $rose(serialEventFlag) |-> busStatusCodeReg inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28,
    8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58}) else $error("bad status");
  a_rx_codes: assert property (
    serialEventFlag && busStatusCodeReg inside {8'h40, 8'h48, 8'h50, 8'h58} |->
    masterReceiveMode) else $error("receive mode off");
  a_tx_codes: assert property (
    serialEventFlag && busStatusCodeReg inside {8'h18, 8'h20, 8'h28, 8'h30} |->
    !masterReceiveMode) else $error("receive mode on");
endmodule : twm_chk

bind two_wire_master_status_engine twm_chk #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_twm_chk (
  .clk(clk), .reset(reset), .clkEn(clkEn), .sclOeN(sclOeN), .sdaOeN(sdaOeN),
  .ctrlWrite(ctrlWrite), .ctrlClearEvent(ctrlClearEvent), .dataWrite(dataWrite),
  .startRequestBit(startRequestBit), .stopRequestBit(stopRequestBit),
  .serialEventFlag(serialEventFlag), .busStatusCodeReg(busStatusCodeReg),
  .busDataReg(busDataReg), .masterReceiveMode(masterReceiveMode));

// ==== testbench/twm_slave.sv ====
// Behavioural slave on the two-wire bus.
`timescale 1ns/100ps
module twm_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic ackOn,
  input wire logic [7:0] txByte,
  output logic sdaRel
);
  int n = 0;
  logic [7:0] sh = 8'h00;
  logic rd = 1'b0, adr = 1'b0, go = 1'b0;
  // -------------
  // Bus behaviour
  // -------------
  initial sdaRel = 1'b1;
  always @(negedge sda) if (scl) begin
    n = 0;
    adr = 1'b1;
    go = 1'b0;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n = n + 1;
    if (n == 9 && rd && !adr) go = !sda;
  end
  always @(negedge scl) begin
    sdaRel = 1'b1;
    if (n == 8 && adr) begin
      rd = sh[0];
      sdaRel = !(ackOn && sh[7:1] == ADDR);
      go = !sdaRel && rd;
    end else if (n == 8 && !rd) sdaRel = !ackOn;
    else if (n == 9) begin
      n = 0;
      adr = 1'b0;
    end
    if (n < 8 && go) sdaRel = txByte[7 - n];
  end
endmodule : twm_slave

// ==== testbench/two_wire_master_status_engine_tb.sv ====
// Self-checking bench for the two-wire master status engine.
`timescale 1ns/100ps
module two_wire_master_status_engine_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] code;
    logic mode;
    logic stop_request_bit;
  } twm_row_t;
  localparam twm_row_t ROWS [4] = '{'{8'h54, 8'h18, 1'b0, 1'b1}, '{8'h56, 8'h20, 1'b0, 1'b1},
    '{8'h55, 8'h40, 1'b1, 1'b1}, '{8'h57, 8'h48, 1'b1, 1'b0}};
  logic clk = 1'b0, busClk = 1'b0, reset = 1'b1, ctrlWrite = 1'b0, ctrlStart = 1'b0;
  logic ctrlStop = 1'b0, ctrlAck = 1'b0, dataWrite = 1'b0, ackOn = 1'b1, jam = 1'b0;
  logic en = 1'b1, clr = 1'b1, ce = 1'b1;
  logic [7:0] dataIn = 8'h00;
  logic sclOut, sclOeN, sdaOut, sdaOeN, sRel, enBit, staBit, stoBit, ackBit, flag, rxMode;
  logic [7:0] code, data;
  int nErrors = 0, compares = 0, cycles = 0;
  wire scl = sclOeN ? 1'b1 : sclOut;
  wire sda = (sdaOeN ? 1'b1 : sdaOut) & sRel & !jam;
  two_wire_master_status_engine #(.QUARTER_CYCLES(2)) u_two_wire_master_status_engine (
    .clk(clk), .reset(reset), .clkEn(ce), .busClk(busClk), .sclIn(scl), .sdaIn(sda),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .ctrlWrite(ctrlWrite), .ctrlEnable(en), .ctrlStart(ctrlStart), .ctrlStop(ctrlStop),
    .ctrlAck(ctrlAck), .ctrlClearEvent(clr), .dataWrite(dataWrite), .dataIn(dataIn),
    .interfaceEnableBit(enBit), .startRequestBit(staBit), .stopRequestBit(stoBit),
    .ackEnableBit(ackBit), .serialEventFlag(flag), .busStatusCodeReg(code),
    .busDataReg(data), .masterReceiveMode(rxMode));
  twm_slave u_twm_slave (.scl(scl), .sda(sda), .ackOn(ackOn), .txByte(8'ha5), .sdaRel(sRel));
  initial forever #2.5 clk = !clk;
  initial begin
    #3.3;
    forever #7.5 busClk = !busClk;
  end
  task automatic conclude();
    if (nErrors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nErrors++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic s, input logic p, input logic a);
    @(posedge clk);
    ctrlWrite <= 1'b1;
    ctrlStart <= s;
    ctrlStop <= p;
    ctrlAck <= a;
    @(posedge clk);
    ctrlWrite <= 1'b0;
  endtask : wr
  task automatic ld(input logic [7:0] b);
    @(posedge clk);
    dataWrite <= 1'b1;
    dataIn <= b;
    @(posedge clk);
    dataWrite <= 1'b0;
  endtask : ld
  task automatic wf(input logic [7:0] c);
    repeat (3000) begin
      @(negedge clk);
      if (flag === 1'b1) break;
    end
    chk("status", code, c);
  endtask : wf
  task automatic wi();
    repeat (3000) begin
      @(negedge clk);
      if (code === 8'hf8 && stoBit === 1'b0) break;
    end
    chk("idle", {stoBit, flag, code[5:0]}, 8'h38);
  endtask : wi
  task automatic xfer(input logic [7:0] b, input logic a, input logic [7:0] c);
    ld(b);
    wr(1'b0, 1'b0, a);
    wf(c);
  endtask : xfer
  // --------
  // Stimulus
  // --------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("reset", {flag, rxMode, sclOeN, sdaOeN, enBit, staBit, stoBit, ackBit}, 8'h30);
    chk("status", code, 8'hf8);
    ld(8'h77);
    @(negedge clk);
    chk("data", data, 8'h00);
    foreach (ROWS[k]) begin
      wr(1'b1, 1'b0, 1'b0);
      wf(8'h08);
      xfer(ROWS[k].addr, 1'b0, ROWS[k].code);
      chk("mode", {7'h00, rxMode}, {7'h00, ROWS[k].mode});
      wr(1'b0, ROWS[k].stop_request_bit, 1'b0);
      wi();
    end
    wr(1'b1, 1'b0, 1'b0);
    wf(8'h08);
    xfer(8'h54, 1'b0, 8'h18);
    xfer(8'h3c, 1'b0, 8'h28);
    ackOn <= 1'b0;
    xfer(8'hc3, 1'b0, 8'h30);
    ackOn <= 1'b1;
    wr(1'b1, 1'b0, 1'b0);
    wf(8'h10);
    xfer(8'h55, 1'b1, 8'h40);
    wr(1'b0, 1'b0, 1'b1);
    wf(8'h50);
    chk("data", data, 8'ha5);
    wr(1'b0, 1'b0, 1'b0);
    wf(8'h58);
    chk("data", data, 8'ha5);
    wr(1'b1, 1'b0, 1'b0);
    wf(8'h10);
    xfer(8'h54, 1'b0, 8'h18);
    chk("mode", {7'h00, rxMode}, 8'h00);
    wr(1'b1, 1'b1, 1'b0);
    wf(8'h08);
    chk("stop", {7'h00, stoBit}, 8'h00);
    xfer(8'h54, 1'b0, 8'h18);
    jam <= 1'b1;
    xfer(8'hff, 1'b0, 8'h38);
    jam <= 1'b0;
    wr(1'b0, 1'b0, 1'b0);
    wi();
    chk("lines", {6'h00, sclOeN, sdaOeN}, {7'h00, rxMode} | 8'h03);
    @(posedge clk);
    en <= 1'b0;
    wr(1'b1, 1'b0, 1'b0);
    repeat (100) @(negedge clk);
    chk("disabled", {sclOeN, flag, code[5:0]}, 8'hb8);
    @(posedge clk);
    en <= 1'b1;
    wr(1'b1, 1'b0, 1'b0);
    wf(8'h08);
    ld(8'h54);
    clr <= 1'b0;
    wr(1'b0, 1'b0, 1'b0);
    ce <= 1'b0;
    clr <= 1'b1;
    wr(1'b0, 1'b0, 1'b0);
    repeat (100) @(negedge clk);
    chk("held", {flag, code[6:0]}, 8'h88);
    chk("held", {7'h00, sclOeN}, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    wr(1'b0, 1'b0, 1'b0);
    wf(8'h18);
    jam <= 1'b1;
    xfer(8'hff, 1'b0, 8'h38);
    wr(1'b1, 1'b0, 1'b0);
    repeat (100) @(negedge clk);
    chk("wait", {6'h00, flag, sdaOeN}, 8'h01);
    jam <= 1'b0;
    wf(8'h08);
    ld(8'h54);
    wr(1'b0, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("reset", {flag, rxMode, sclOeN, sdaOeN, enBit, staBit, stoBit, ackBit}, 8'h30);
    chk("outputs", {code[7:2], sclOut, sdaOut}, 8'hf8);
    conclude();
  end
endmodule : two_wire_master_status_engine_tb
